// ===== hdl/dcp_pkg.sv
// Constants and carrier types for the converter clock-path control block.
// Assumes a single REF_CLK domain and an APB master with 32-bit data.
package dcp_pkg;
    // APB request bundle, driven by the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dcp_apb_req_s;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] LOOP_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam logic [11:0] SCNT_OFS = 12'h00C;

    // CTRL bit positions
    localparam int LOOP_EN_BIT = 0;
    localparam int SLEEP_BIT   = 1;
    localparam int BUF_EN_BIT  = 2;

    // LOOP field positions
    localparam int P_LSB   = 0;
    localparam int M_LSB   = 8;
    localparam int VCO_LSB = 16;
    localparam int CP_LSB  = 24;

    // STATUS field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_CP_LSB   = 2;
    localparam int ST_DIV_LSB  = 8;
    localparam int ST_RANGE    = 20;
    localparam int ST_FILTER   = 21;

    // Reset values
    localparam logic       LOOP_EN_RST = 1'b0;
    localparam logic       SLEEP_RST   = 1'b1;
    localparam logic       BUF_EN_RST  = 1'b1;
    localparam logic [2:0] P_RST       = 3'h4;
    localparam logic [7:0] M_RST       = 8'h04;
    localparam logic [5:0] VCO_RST     = 6'h20;
    localparam logic [1:0] CP_RST      = 2'h1;

    // Charge-pump codes
    localparam logic [1:0] CP_SINGLE_CODE = 2'h1;
    localparam logic [1:0] CP_DOUBLE_CODE = 2'h3;

    // Overall loop division limits
    localparam logic [10:0] DIV_MIN    = 11'd24;
    localparam logic [10:0] DIV_MAX    = 11'd480;
    localparam logic [10:0] DIV_FILTER = 11'd120;

    // Pin bit positions inside the synchroniser vector
    localparam int PIN_CONV   = 0;
    localparam int PIN_WCLK   = 1;
    localparam int PIN_FRAME  = 2;
    localparam int PIN_SYNC   = 3;
    localparam int PIN_STROBE = 4;
    localparam int PIN_CTL    = 5;

    // Read pointer start, ahead of the write pointer for margin
    localparam int RPTR_RST = 4;

    typedef enum logic [1:0] {
        CLK_DIRECT       = 2'b00,
        CLK_LOOP         = 2'b01,
        CLK_LOOP_ASLEEP  = 2'b10,
        CLK_DIRECT_AWAKE = 2'b11
    } dcp_clk_mode_e;
endpackage

// ===== hdl/dcp_top.sv
// Clock-path and loop configuration control with input word handoff.
// Assumes pins are asynchronous to REF_CLK and an APB master drives APB_REQ.
`timescale 1ns/1ps
module dcp_top #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    input  wire dcp_pkg::dcp_apb_req_s APB_REQ,
    output logic [31:0]               PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic                 CONVERTER_CLOCK_IN,
    input  wire logic                 INPUT_WORD_CLOCK,
    input  wire logic [W-1:0]         WORD_IN,
    input  wire logic                 FRAME_IN,
    input  wire logic                 SYNC_IN,
    input  wire logic                 STROBE_IN,
    output logic                      SEL_LOOP_CLK,
    output logic                      LOOP_PWRDN,
    output logic [2:0]                VCO_PRESCALE,
    output logic [7:0]                REF_DIVIDE,
    output logic [5:0]                VCO_COARSE,
    output logic                      CP_SINGLE,
    output logic                      CP_DOUBLE,
    output logic                      OUTPUT_STROBE,
    output logic [W-1:0]              WORD_OUT,
    output logic                      WORD_VALID,
    output logic                      FRAME_OUT,
    output logic                      SYNC_OUT
);
    import dcp_pkg::*;

    localparam int PIN_W = PIN_CTL + W;
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] RPTR_START = PTR_W'(RPTR_RST);

    typedef struct packed {
        logic [PIN_W-1:0]            s1;
        logic [PIN_W-1:0]            s2;
        logic [PIN_W-1:0]            s3;
        logic [PIN_W-1:0]            lvl;
        logic                        loop_en;
        logic                        sleep;
        logic                        buf_en;
        logic [2:0]                  p;
        logic [7:0]                  m;
        logic [5:0]                  vco;
        logic [1:0]                  cp;
        logic                        cp_sgl;
        logic                        cp_dbl;
        logic [7:0]                  fb_cnt;
        logic                        strobe;
        logic [15:0]                 strobe_cnt;
        logic [PTR_W-1:0]            wptr;
        logic [PTR_W-1:0]            rptr;
        logic [DEPTH-1:0][W-1:0]     mem;
        logic [W-1:0]                word_out;
        logic                        word_vld;
        logic                        frame_out;
        logic                        sync_out;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
    } dcp_state_s;

    dcp_state_s state_reg;
    dcp_state_s state_next;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [10:0] div_product(input logic [2:0] p, input logic [7:0] m);
        div_product = 11'(p) * 11'(m);
    endfunction

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] rise;
    logic [W-1:0]     data_now;
    logic [7:0]       mdiv;
    logic [10:0]      product;
    logic             loop_run;
    logic             conv_edge;
    logic             word_edge;
    logic             ext_strobe;
    logic             setup;
    logic             wr_done;
    dcp_clk_mode_e    mode;

    assign pins     = {WORD_IN, STROBE_IN, SYNC_IN, FRAME_IN, INPUT_WORD_CLOCK,
                       CONVERTER_CLOCK_IN};
    assign data_now = state_reg.lvl[PIN_W-1:PIN_CTL];
    assign mdiv     = (state_reg.m == 8'h00) ? 8'h01 : state_reg.m;
    assign product  = div_product(state_reg.p, state_reg.m);
    assign loop_run = state_reg.loop_en & ~state_reg.sleep;
    assign setup    = APB_REQ.psel & ~APB_REQ.penable;
    assign wr_done  = APB_REQ.psel & APB_REQ.penable & state_reg.pready & APB_REQ.pwrite;

    always_comb begin
        state_next = state_reg;
        // Change counts only once stages two and three agree
        state_next.s1 = pins;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < PIN_W; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.lvl[i] = state_reg.s3[i];
            end
        end
        rise       = state_next.lvl & ~state_reg.lvl;
        conv_edge  = rise[PIN_CONV];
        word_edge  = rise[PIN_WCLK];
        ext_strobe = rise[PIN_STROBE];

        case ({state_reg.sleep, state_reg.loop_en})
            2'b00: mode = CLK_DIRECT_AWAKE;
            2'b01: mode = CLK_LOOP;
            2'b10: mode = CLK_DIRECT;
            2'b11: mode = CLK_LOOP_ASLEEP;
            default: mode = CLK_DIRECT;
        endcase

        // Strobe source
        state_next.strobe = 1'b0;
        if (state_reg.loop_en) begin
            if (!loop_run) begin
                state_next.fb_cnt = 8'h00;
            end else if (conv_edge) begin
                if (state_reg.fb_cnt >= mdiv - 8'h01) begin
                    state_next.fb_cnt = 8'h00;
                    state_next.strobe = 1'b1;
                end else begin
                    state_next.fb_cnt = state_reg.fb_cnt + 8'h01;
                end
            end
        end else begin
            state_next.fb_cnt = 8'h00;
            state_next.strobe = ext_strobe;
        end
        if (state_next.strobe) begin
            state_next.strobe_cnt = state_reg.strobe_cnt + 16'h0001;
        end

        // Word handoff
        state_next.word_vld  = 1'b0;
        state_next.frame_out = 1'b0;
        state_next.sync_out  = 1'b0;
        if (word_edge) begin
            state_next.word_vld = 1'b1;
            if (state_reg.buf_en) begin
                state_next.mem[state_reg.wptr] = data_now;
                state_next.word_out  = state_reg.mem[state_reg.rptr];
                state_next.wptr      = ptr_inc(state_reg.wptr);
                state_next.rptr      = ptr_inc(state_reg.rptr);
                state_next.frame_out = state_reg.lvl[PIN_FRAME];
                state_next.sync_out  = state_reg.lvl[PIN_SYNC];
            end else begin
                state_next.word_out = data_now;
            end
        end
        // Pointer realignment, only while the buffer is in use
        if (state_reg.buf_en) begin
            if (rise[PIN_FRAME] | rise[PIN_SYNC]) begin
                state_next.wptr = '0;
            end
            if (state_next.strobe) begin
                state_next.rptr = RPTR_START;
            end
        end

        // APB: registered answer, one wait-free access phase
        state_next.pready  = setup & ~state_reg.pready;
        state_next.pslverr = 1'b0;
        state_next.prdata  = 32'h0000_0000;
        if (setup) begin
            case (APB_REQ.paddr)
                CTRL_OFS: begin
                    state_next.prdata[LOOP_EN_BIT] = state_reg.loop_en;
                    state_next.prdata[SLEEP_BIT]   = state_reg.sleep;
                    state_next.prdata[BUF_EN_BIT]  = state_reg.buf_en;
                end
                LOOP_OFS: begin
                    state_next.prdata[P_LSB+:3]   = state_reg.p;
                    state_next.prdata[M_LSB+:8]   = state_reg.m;
                    state_next.prdata[VCO_LSB+:6] = state_reg.vco;
                    state_next.prdata[CP_LSB+:2]  = state_reg.cp;
                end
                STAT_OFS: begin
                    state_next.prdata[ST_MODE_LSB+:2] = mode;
                    state_next.prdata[ST_CP_LSB+:2]   = {state_reg.cp_dbl, state_reg.cp_sgl};
                    state_next.prdata[ST_DIV_LSB+:11] = product;
                    // Guidance flags only; software owns the choice
                    state_next.prdata[ST_RANGE]  = (product < DIV_MIN) | (product > DIV_MAX);
                    state_next.prdata[ST_FILTER] = (product > DIV_FILTER) & ~state_reg.cp_dbl;
                end
                SCNT_OFS: begin
                    state_next.prdata[15:0] = state_reg.strobe_cnt;
                end
                default: begin
                    state_next.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_done) begin
            case (APB_REQ.paddr)
                CTRL_OFS: begin
                    state_next.loop_en = APB_REQ.pwdata[LOOP_EN_BIT];
                    state_next.sleep   = APB_REQ.pwdata[SLEEP_BIT];
                    state_next.buf_en  = APB_REQ.pwdata[BUF_EN_BIT];
                end
                LOOP_OFS: begin
                    state_next.p   = APB_REQ.pwdata[P_LSB+:3];
                    state_next.m   = APB_REQ.pwdata[M_LSB+:8];
                    state_next.vco = APB_REQ.pwdata[VCO_LSB+:6];
                    state_next.cp  = APB_REQ.pwdata[CP_LSB+:2];
                end
                default: begin
                    state_next.cp = state_next.cp;
                end
            endcase
        end
        // Codes 00 and 10 leave the pump off
        state_next.cp_sgl = (state_next.cp == CP_SINGLE_CODE);
        state_next.cp_dbl = (state_next.cp == CP_DOUBLE_CODE);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg         <= '0;
            state_reg.loop_en <= LOOP_EN_RST;
            state_reg.sleep   <= SLEEP_RST;
            state_reg.buf_en  <= BUF_EN_RST;
            state_reg.p       <= P_RST;
            state_reg.m       <= M_RST;
            state_reg.vco     <= VCO_RST;
            state_reg.cp      <= CP_RST;
            state_reg.cp_sgl  <= 1'b1;
            state_reg.rptr    <= RPTR_START;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PRDATA        = state_reg.prdata;
    assign PREADY        = state_reg.pready;
    assign PSLVERR       = state_reg.pslverr;
    assign SEL_LOOP_CLK  = state_reg.loop_en;
    assign LOOP_PWRDN    = state_reg.sleep;
    assign VCO_PRESCALE  = state_reg.p;
    assign REF_DIVIDE    = state_reg.m;
    assign VCO_COARSE    = state_reg.vco;
    assign CP_SINGLE     = state_reg.cp_sgl;
    assign CP_DOUBLE     = state_reg.cp_dbl;
    assign OUTPUT_STROBE = state_reg.strobe;
    assign WORD_OUT      = state_reg.word_out;
    assign WORD_VALID    = state_reg.word_vld;
    assign FRAME_OUT     = state_reg.frame_out;
    assign SYNC_OUT      = state_reg.sync_out;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    logic [PTR_W-1:0] wptr_now;
    logic [7:0]       cnt_now;
    assign wptr_now = state_reg.wptr;
    assign cnt_now  = state_reg.fb_cnt;

    a_bypass_word: assert property (
        !state_reg.buf_en && word_edge |=> WORD_VALID && WORD_OUT == $past(data_now))
        else $error("bypass word not passed directly");
    a_bypass_ptr: assert property (
        !state_reg.buf_en && word_edge |=> wptr_now == $past(wptr_now))
        else $error("pointer moved in bypass");
    a_bypass_ctl: assert property (
        !state_reg.buf_en |=> !FRAME_OUT && !SYNC_OUT)
        else $error("frame or sync forwarded in bypass");
    a_ctrl_write: assert property (
        wr_done && APB_REQ.paddr == CTRL_OFS
        |=> SEL_LOOP_CLK == $past(APB_REQ.pwdata[LOOP_EN_BIT]))
        else $error("loop enable not written");
    a_sleep_quiet: assert property (
        SEL_LOOP_CLK && LOOP_PWRDN |=> !OUTPUT_STROBE ##1 !OUTPUT_STROBE)
        else $error("strobe while loop asleep");
    a_loop_count: assert property (
        loop_run && conv_edge && cnt_now < mdiv - 8'h01 |=> cnt_now == $past(cnt_now) + 8'h01)
        else $error("feedback divider stalled");
    a_loop_strobe: assert property (
        loop_run && conv_edge && cnt_now >= mdiv - 8'h01 |=> OUTPUT_STROBE && cnt_now == 8'h00)
        else $error("feedback strobe missing");
    a_ext_ignored: assert property (
        SEL_LOOP_CLK && ext_strobe && !conv_edge |=> !OUTPUT_STROBE)
        else $error("external strobe used in loop mode");
    a_loop_fields: assert property (
        wr_done && APB_REQ.paddr == LOOP_OFS
        |=> VCO_PRESCALE == $past(APB_REQ.pwdata[2:0]) && REF_DIVIDE == $past(APB_REQ.pwdata[15:8]))
        else $error("loop fields not written");
    a_pump_decode: assert property (
        CP_DOUBLE |-> !CP_SINGLE && $past(state_next.cp) == CP_DOUBLE_CODE)
        else $error("charge pump decode wrong");
    a_apb_answer: assert property (
        setup && !PREADY |=> PREADY ##1 !PREADY)
        else $error("apb answer timing wrong");
    a_direct_strobe: assert property (
        !SEL_LOOP_CLK && ext_strobe |=> OUTPUT_STROBE)
        else $error("external strobe lost in direct mode");
    a_sleep_count: assert property (
        SEL_LOOP_CLK && LOOP_PWRDN |=> cnt_now == 8'h00)
        else $error("feedback divider ran while asleep");
    // Fields move only on a completed write, never from pin activity
    a_fields_hold: assert property (
        !wr_done |=> $stable(VCO_PRESCALE) && $stable(REF_DIVIDE) && $stable(VCO_COARSE))
        else $error("loop fields changed without a write");
    a_sleep_write: assert property (
        wr_done && APB_REQ.paddr == CTRL_OFS |=> LOOP_PWRDN == $past(APB_REQ.pwdata[SLEEP_BIT]))
        else $error("loop sleep not written");

    c_loop_strobe: cover property (SEL_LOOP_CLK && OUTPUT_STROBE);
    c_bypass_word: cover property (!state_reg.buf_en && WORD_VALID);
    c_buffer_word: cover property (state_reg.buf_en && WORD_VALID && FRAME_OUT);
    c_apb_error:   cover property (PREADY && PSLVERR);
endmodule

// ===== verification/dcp_src_model.sv
// Behavioural external clock and word source for the clock-path block.
// Assumes pacing by REF_CLK; each level but the inverted word between back-to-back send_word calls is held 4+ cycles for the 3-flop filters.
`timescale 1ns/1ps
module dcp_src_model (
    input  wire logic        clk,
    output logic             conv_clk,
    output logic             word_clk,
    output logic [15:0]      word,
    output logic             frame,
    output logic             sync,
    output logic             strobe
);
    initial begin
        conv_clk = 1'b0;
        word_clk = 1'b0;
        word     = 16'h0000;
        frame    = 1'b0;
        sync     = 1'b0;
        strobe   = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Converter clock only runs when asked, idles low between bursts
    task automatic conv_edges(input int n);
        repeat (n) begin
            @(posedge clk) conv_clk <= 1'b1;
            hold(4);
            conv_clk <= 1'b0;
            hold(3);
        end
    endtask

    // Data held both sides of the word edge; inverted after so stale data shows
    task automatic send_word(input logic [15:0] w);
        @(posedge clk) word <= w;
        hold(4);
        word_clk <= 1'b1;
        hold(4);
        word_clk <= 1'b0;
        hold(4);
        word <= ~w;
    endtask

    task automatic pulse_strobe();
        @(posedge clk) strobe <= 1'b1;
        hold(4);
        strobe <= 1'b0;
        hold(4);
    endtask

    task automatic set_frame(input logic v);
        @(posedge clk) frame <= v;
        hold(4);
    endtask

    task automatic set_sync(input logic v);
        @(posedge clk) sync <= v;
        hold(4);
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the clock-path control block.
// Assumes the source model drives all pins and the bench is the APB master.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
    import dcp_pkg::*;
    logic         ref_clk;
    logic         rst_n;
    dcp_apb_req_s apb_req;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         conv_clk, word_clk, frame, sync, strobe_in;
    logic [15:0]  word_in, word_out, got_word = 16'h0000;
    logic         sel_loop_clk, loop_pwrdn, cp_single, cp_double;
    logic [2:0]   vco_prescale;
    logic [7:0]   ref_divide;
    logic [5:0]   vco_coarse;
    logic         output_strobe, word_valid, frame_out, sync_out;
    logic         got_frame = 1'b0;
    logic         got_sync  = 1'b0;
    logic [20:0]  pins_v;
    logic [31:0]  rd;
    logic         err;
    int           fail_count = 0;
    int           comparisons = 0;
    int           strobe_seen = 0;

    assign pins_v = {sel_loop_clk, loop_pwrdn, vco_prescale, ref_divide, vco_coarse,
                     cp_single, cp_double};

    dcp_top u_dut (
        .REF_CLK(ref_clk), .RST_N(rst_n), .APB_REQ(apb_req), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CONVERTER_CLOCK_IN(conv_clk),
        .INPUT_WORD_CLOCK(word_clk), .WORD_IN(word_in), .FRAME_IN(frame),
        .SYNC_IN(sync), .STROBE_IN(strobe_in), .SEL_LOOP_CLK(sel_loop_clk),
        .LOOP_PWRDN(loop_pwrdn), .VCO_PRESCALE(vco_prescale), .REF_DIVIDE(ref_divide),
        .VCO_COARSE(vco_coarse), .CP_SINGLE(cp_single), .CP_DOUBLE(cp_double),
        .OUTPUT_STROBE(output_strobe), .WORD_OUT(word_out), .WORD_VALID(word_valid),
        .FRAME_OUT(frame_out), .SYNC_OUT(sync_out)
    );

    dcp_src_model u_src (
        .clk(ref_clk), .conv_clk(conv_clk), .word_clk(word_clk), .word(word_in),
        .frame(frame), .sync(sync), .strobe(strobe_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Pulses stand one cycle, so they are caught at the edge after they appear
    always @(posedge ref_clk) begin
        if (output_strobe === 1'b1) begin
            strobe_seen <= strobe_seen + 1;
        end
        if (word_valid === 1'b1) begin
            got_word  <= word_out;
            got_frame <= frame_out;
            got_sync  <= sync_out;
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fail_count++;
            end_sim();
        end
        rd  = prdata;
        err = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    initial begin
        rst_n     = 1'b0;
        apb_req   = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        `CHK("reset pins", {2'b01, 3'h4, 8'h04, 6'h20, 2'b10}, pins_v)
        rdc(CTRL_OFS, 32'h0000_0006, "ctrl");
        rdc(LOOP_OFS, 32'h0120_0404, "loop");
        rdc(STAT_OFS, 32'h0010_1004, "status");
        rdc(SCNT_OFS, 32'h0000_0000, "strobe count");
        // Unmapped place: refused, and must not disturb control
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        `CHK("slverr write", 1'b1, err)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("slverr read", {1'b1, 32'h0}, {err, rd})
        rdc(CTRL_OFS, 32'h0000_0006, "ctrl kept");
        // Every pump code, divide 7 x 32 = 224 sits above the filter threshold
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, LOOP_OFS, {6'h0, c[1:0], 2'b00, 6'h3F, 8'h20, 5'h0, 3'h7});
            @(negedge ref_clk);
            `CHK("pump", {c == 1, c == 3}, {cp_single, cp_double})
            rdc(STAT_OFS, {10'h0, c != 3, 2'b00, 11'd224, 4'h0, c == 3, c == 1, 2'b00},
                "status pump");
        end
        `CHK("fields", {3'h7, 8'h20, 6'h3F}, {vco_prescale, ref_divide, vco_coarse})
        // Loop mode at the lowest legal divide 6 x 4 = 24
        apb(1'b1, LOOP_OFS, 32'h0100_0406);
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        @(negedge ref_clk);
        `CHK("loop sel", 2'b10, {sel_loop_clk, loop_pwrdn})
        u_src.conv_edges(12);
        repeat (4) @(posedge ref_clk);
        `CHK("loop strobes", 3, strobe_seen)
        rdc(SCNT_OFS, 32'h0000_0003, "strobe count");
        rdc(STAT_OFS, 32'h0000_1805, "status loop");
        // Enabled but asleep: loop clock chosen, no strobe
        apb(1'b1, CTRL_OFS, 32'h0000_0003);
        @(negedge ref_clk);
        `CHK("asleep sel", 2'b11, {sel_loop_clk, loop_pwrdn})
        rdc(STAT_OFS, 32'h0000_1806, "status asleep");
        u_src.conv_edges(8);
        repeat (4) @(posedge ref_clk);
        `CHK("asleep strobes", 3, strobe_seen)
        // Direct clock: external strobe passes instead
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        @(negedge ref_clk);
        `CHK("direct sel", 2'b00, {sel_loop_clk, loop_pwrdn})
        rdc(STAT_OFS, 32'h0000_1807, "status direct");
        u_src.pulse_strobe();
        repeat (4) @(posedge ref_clk);
        `CHK("direct strobe", 4, strobe_seen)
        // Bypass: word straight through, frame and sync high but not forwarded
        u_src.set_frame(1'b1);
        u_src.set_sync(1'b1);
        u_src.send_word(16'hA5A5);
        repeat (4) @(posedge ref_clk);
        `CHK("bypass word", {16'hA5A5, 2'b00}, {got_word, got_frame, got_sync})
        u_src.set_frame(1'b0);
        u_src.set_sync(1'b0);
        // Buffer mode: write pointer to 0, read pointer to 4, four-word delay
        apb(1'b1, CTRL_OFS, 32'h0000_0004);
        u_src.set_frame(1'b1);
        u_src.pulse_strobe();
        for (int k = 0; k < 8; k++) begin
            u_src.send_word(16'h1000 + k[15:0]);
        end
        repeat (4) @(posedge ref_clk);
        `CHK("buffer word", {16'h1003, 2'b10}, {got_word, got_frame, got_sync})
        // Sync edge moves only the write side, so the delay drops to two words
        for (int k = 0; k < 5; k++) begin
            if (k == 2) begin
                u_src.set_sync(1'b1);
            end
            u_src.send_word(16'h2000 + k[15:0]);
        end
        repeat (4) @(posedge ref_clk);
        `CHK("sync realign", {16'h2002, 2'b11}, {got_word, got_frame, got_sync})
        end_sim();
    end
endmodule
